// ### hdl/exc_arb_pkg.sv
/*
  constants for the exception arbiter: register offsets, vectors,
  priority levels, stack layout. assumes a 16-bit address space.
*/
package exc_arb_pkg;
  localparam int          NUM_LEVELS       = 12;
  localparam int          NUM_HW           = 11;
  localparam logic [15:0] PENDING_LOW_ADDR = 16'hfe04;
  localparam logic [15:0] PENDING_HI_ADDR  = 16'hfe05;
  localparam logic [15:0] PENDING_X_ADDR   = 16'hfe06;
  localparam logic [15:0] CCR_ADDR         = 16'hfe10;
  localparam logic [15:0] ENABLE_LO_ADDR   = 16'hfe11;
  localparam logic [15:0] ENABLE_HI_ADDR   = 16'hfe12;
  localparam logic [7:0]  PENDING_RESET    = 8'h00;
  localparam logic [15:0] RESET_VECTOR     = 16'hfffe;
  localparam logic [15:0] SWI_VECTOR       = 16'hfffc;
  localparam logic [15:0] SP_RESET         = 16'h00ff;
  localparam int          IMASK_BIT        = 3;
  localparam int          PEND_LOW_SHIFT   = 2;
  localparam logic [7:0]  CCR_RESET        = 8'h08;
  localparam logic [2:0]  STK_BYTES        = 3'h5;
  typedef enum logic [1:0] {
    STK_IDLE, STK_ENTRY, STK_RETURN
  } stack_phase_e;
endpackage

// ### hdl/exception_interrupt_arbiter.sv
/*
  exception control: latches requests, arbitrates by fixed priority,
  sequences stacking, vector fetch and return for the core.
  assumes a core that raises insn_done at each instruction boundary,
  pulses trap_insn / return_insn, and accepts one memory step per cycle.
*/
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - requests latched every clock; the winner is taken only at an instruction boundary.
// - winner presented as a constant vector select to the core.
// - latched request follows its request line every clock; it is not held until serviced.
// - entry stacks registers, then sets the global mask bit.
// - return instruction unstacks the saved registers to resume.
// - hardware requests never abort an instruction; checked at boundaries.
// - take request only if global mask clear and source enabled.
// - several pending: highest priority served first.
// - request pending at return is taken before the next instruction; here it waits for the next insn_done after the unstack.
// - high index register is never stacked; handler must save it.
// - software trap interrupts regardless of global mask.
// - software trap stacks pc; hardware interrupt stacks pc minus one.
// - levels 0 (trap) to 11 (synth); one vector pair each, descending.
// - global mask gates every source except the software trap and the break request.
// - one flag per maskable level, set while its request is present.
// - low flags register holds levels 6..1 in bits 7..2, read-only.
// - two low bits of the low flags register read zero.
// - resets share top priority above all interrupts, never arbitrated.
// - break request forces the software trap vector.
module exception_interrupt_arbiter
  import exc_arb_pkg::*;
#(
  parameter int LEVELS = NUM_LEVELS
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [10:0] irq_req,
  input  wire logic        insn_done,
  input  wire logic        trap_insn,
  input  wire logic        return_insn,
  input  wire logic        break_req,
  input  wire logic [15:0] core_pc,
  input  wire logic [7:0]  core_a,
  input  wire logic [7:0]  core_x,
  input  wire logic [7:0]  core_ccr,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  output logic             core_hold,
  output logic [3:0]       vector_sel,
  output logic [15:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  output logic             mem_we,
  output logic             mem_re,
  output logic             load_pc,
  output logic [15:0]      new_pc,
  output logic             load_regs,
  output logic [7:0]       new_a,
  output logic [7:0]       new_x,
  output logic [7:0]       ccr_out
);

  if (LEVELS != NUM_LEVELS) begin : g_level_check
    $error("level count must match the vector table");
  end

  // ******************************
  // pending flags and arbitration
  // ******************************
  logic [10:0]  pend_r, pend_nxt;
  logic [10:0]  enable_r, enable_nxt;
  logic [7:0]   ccr_r, ccr_nxt;
  logic [10:0]  eligible;
  logic [3:0]   winner;
  logic         hw_take;

  always_comb begin
    pend_nxt = irq_req;
    eligible = pend_r & enable_r & {11{~ccr_r[IMASK_BIT]}};
    winner   = 4'h0;
    for (int i = NUM_HW - 1; i >= 0; i--) begin
      if (eligible[i]) winner = 4'(i + 1);
    end
    hw_take = |eligible;
  end

  // ******************************
  // stacking sequencer
  // ******************************
  stack_phase_e phase_r, phase_nxt;
  logic [2:0]   step_r, step_nxt;
  logic [15:0]  sp_r, sp_nxt;
  logic [3:0]   vsel_r, vsel_nxt;
  logic [15:0]  ret_pc_r, ret_pc_nxt;
  logic [7:0]   a_r, a_nxt, x_r, x_nxt;
  logic [15:0]  maddr_r, maddr_nxt;
  logic [7:0]   mwd_r, mwd_nxt;
  logic         mwe_r, mwe_nxt, mre_r, mre_nxt;
  logic         ldpc_r, ldpc_nxt, ldr_r, ldr_nxt;
  logic [15:0]  npc_r, npc_nxt;
  logic [15:0]  vaddr;
  logic [7:0]   rdata_r, rdata_nxt;
  logic         hold_r, hold_nxt;

  assign vaddr = RESET_VECTOR - {11'h000, vsel_r, 1'b0} - 16'h0002;

  always_comb begin
    phase_nxt  = phase_r;
    step_nxt   = step_r;
    sp_nxt     = sp_r;
    vsel_nxt   = vsel_r;
    ret_pc_nxt = ret_pc_r;
    a_nxt      = a_r;
    x_nxt      = x_r;
    ccr_nxt    = ccr_r;
    maddr_nxt  = maddr_r;
    mwd_nxt    = 8'h00;
    mwe_nxt    = 1'b0;
    mre_nxt    = 1'b0;
    ldpc_nxt   = 1'b0;
    ldr_nxt    = 1'b0;
    npc_nxt    = npc_r;
    enable_nxt = enable_r;
    unique case (phase_r)
      STK_IDLE: begin
        if (insn_done) begin
          ccr_nxt = core_ccr;
          a_nxt   = core_a;
          x_nxt   = core_x;
          if (trap_insn || break_req) begin
            vsel_nxt   = 4'h0;
            ret_pc_nxt = core_pc;
            phase_nxt  = STK_ENTRY;
            step_nxt   = 3'h0;
          end else if (return_insn) begin
            phase_nxt = STK_RETURN;
            step_nxt  = 3'h0;
          end else if (hw_take) begin
            vsel_nxt   = winner;
            ret_pc_nxt = core_pc - 16'h0001;
            phase_nxt  = STK_ENTRY;
            step_nxt   = 3'h0;
          end
        end
      end
      STK_ENTRY: begin
        step_nxt = step_r + 3'h1;
        if (step_r < STK_BYTES) begin
          mwe_nxt   = 1'b1;
          maddr_nxt = sp_r;
          sp_nxt    = sp_r - 16'h0001;
          unique case (step_r)
            3'h0:    mwd_nxt = ret_pc_r[7:0];
            3'h1:    mwd_nxt = ret_pc_r[15:8];
            3'h2:    mwd_nxt = x_r;
            3'h3:    mwd_nxt = a_r;
            default: mwd_nxt = ccr_r;
          endcase
          if (step_r == STK_BYTES - 3'h1) ccr_nxt[IMASK_BIT] = 1'b1;
        end else if (step_r == 3'h5) begin
          mre_nxt   = 1'b1;
          maddr_nxt = vaddr;
        end else if (step_r == 3'h6) begin
          mre_nxt   = 1'b1;
          maddr_nxt = vaddr + 16'h0001;
          npc_nxt[15:8] = mem_rdata;
        end else begin
          npc_nxt[7:0] = mem_rdata;
          ldpc_nxt     = 1'b1;
          phase_nxt    = STK_IDLE;
        end
      end
      STK_RETURN: begin
        step_nxt = step_r + 3'h1;
        if (step_r < STK_BYTES) begin
          mre_nxt   = 1'b1;
          sp_nxt    = sp_r + 16'h0001;
          maddr_nxt = sp_r + 16'h0001;
        end
        if (step_r >= 3'h1 && step_r <= STK_BYTES) begin
          unique case (step_r)
            3'h1:    ccr_nxt = mem_rdata;
            3'h2:    a_nxt = mem_rdata;
            3'h3:    x_nxt = mem_rdata;
            3'h4:    npc_nxt[15:8] = mem_rdata;
            default: npc_nxt[7:0] = mem_rdata;
          endcase
        end
        if (step_r == STK_BYTES) begin
          ldpc_nxt  = 1'b1;
          ldr_nxt   = 1'b1;
          phase_nxt = STK_IDLE;
        end
      end
      default: phase_nxt = STK_IDLE;
    endcase
    if (reg_wr && reg_addr == ENABLE_LO_ADDR) enable_nxt[7:0] = reg_wdata;
    if (reg_wr && reg_addr == ENABLE_HI_ADDR) enable_nxt[10:8] = reg_wdata[2:0];
    if (reg_wr && reg_addr == CCR_ADDR && phase_r == STK_IDLE) ccr_nxt = reg_wdata;
    hold_nxt = (phase_nxt != STK_IDLE);
  end

  // ******************************
  // register read port
  // ******************************
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (reg_addr)
      PENDING_LOW_ADDR: rdata_nxt = {pend_r[5:0], 2'b00};
      PENDING_HI_ADDR:  rdata_nxt = {3'b000, pend_r[10:6]};
      CCR_ADDR:         rdata_nxt = ccr_r;
      ENABLE_LO_ADDR:   rdata_nxt = enable_r[7:0];
      ENABLE_HI_ADDR:   rdata_nxt = {5'b00000, enable_r[10:8]};
      default:          rdata_nxt = 8'h00;
    endcase
    if (!reg_rd) rdata_nxt = 8'h00;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pend_r    <= '0;
      enable_r  <= '0;
      ccr_r     <= CCR_RESET;
      phase_r   <= STK_IDLE;
      step_r    <= 3'h0;
      sp_r      <= SP_RESET;
      vsel_r    <= 4'h0;
      ret_pc_r  <= 16'h0000;
      a_r       <= 8'h00;
      x_r       <= 8'h00;
      maddr_r   <= 16'h0000;
      mwd_r     <= 8'h00;
      mwe_r     <= 1'b0;
      mre_r     <= 1'b0;
      ldpc_r    <= 1'b0;
      ldr_r     <= 1'b0;
      npc_r     <= 16'h0000;
      rdata_r   <= PENDING_RESET;
      hold_r    <= 1'b0;
    end else begin
      pend_r    <= pend_nxt;
      enable_r  <= enable_nxt;
      ccr_r     <= ccr_nxt;
      phase_r   <= phase_nxt;
      step_r    <= step_nxt;
      sp_r      <= sp_nxt;
      vsel_r    <= vsel_nxt;
      ret_pc_r  <= ret_pc_nxt;
      a_r       <= a_nxt;
      x_r       <= x_nxt;
      maddr_r   <= maddr_nxt;
      mwd_r     <= mwd_nxt;
      mwe_r     <= mwe_nxt;
      mre_r     <= mre_nxt;
      ldpc_r    <= ldpc_nxt;
      ldr_r     <= ldr_nxt;
      npc_r     <= npc_nxt;
      rdata_r   <= rdata_nxt;
      hold_r    <= hold_nxt;
    end
  end

  always_comb begin
    reg_rdata  = rdata_r;
    core_hold  = hold_r;
    vector_sel = vsel_r;
    mem_addr   = maddr_r;
    mem_wdata  = mwd_r;
    mem_we     = mwe_r;
    mem_re     = mre_r;
    load_pc    = ldpc_r;
    new_pc     = npc_r;
    load_regs  = ldr_r;
    new_a      = a_r;
    new_x      = x_r;
    ccr_out    = ccr_r;
  end

  // ******************************
  // checks
  // ******************************
  AST_MASK_SET: assert property (@(posedge mclk) disable iff (!resetn)
    (phase_r == STK_ENTRY && step_r == 3'h4) |=> ccr_r[IMASK_BIT])
    else $error("mask not set after stacking");
  AST_LOW_BITS: assert property (@(posedge mclk) disable iff (!resetn)
    rdata_r[1:0] == 2'b00 || $past(reg_addr) != PENDING_LOW_ADDR)
    else $error("low flag bits nonzero");
  AST_MASKED: assert property (@(posedge mclk) disable iff (!resetn)
    (phase_r == STK_IDLE && insn_done && core_ccr[IMASK_BIT] && ccr_r[IMASK_BIT]
     && !trap_insn && !break_req && !return_insn) |=> phase_r == STK_IDLE)
    else $error("masked request taken");
  AST_SWI_PC: assert property (@(posedge mclk) disable iff (!resetn)
    (phase_r == STK_IDLE && insn_done && trap_insn) |=> ret_pc_r == $past(core_pc))
    else $error("trap stacked wrong pc");
  AST_ENTRY_LEN: assert property (@(posedge mclk) disable iff (!resetn)
    (phase_r == STK_IDLE && phase_nxt == STK_ENTRY) |=> ##1 mwe_r [*5] ##1 mre_r ##1 mre_r)
    else $error("entry sequence wrong");
  AST_TRAP_TAKEN: assert property (@(posedge mclk) disable iff (!resetn)
    (phase_r == STK_IDLE && insn_done && trap_insn) |=> (phase_r == STK_ENTRY && vsel_r == 4'h0))
    else $error("trap not taken");

endmodule
`default_nettype wire

// ### verif/core_mem_model.sv
/*
  memory at the far side of the arbiter: stack ram and vector rom.
  assumes one memory step per cycle, read data in the strobe's cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module core_mem_model (
  input  wire logic        mclk,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic        mem_we,
  input  wire logic        mem_re,
  output logic [7:0]       mem_rdata
);
  logic [7:0] ram [256];
  logic [7:0] rd_val;
  logic [7:0] last_r = 8'h00;
  // vector bytes follow the address, other reads come from ram
  // idle bus shows the inverse of the last byte read
  always_comb begin
    if (mem_addr[15:8] == 8'hff)
      rd_val = mem_addr[7:0] ^ 8'h3c;
    else
      rd_val = ram[mem_addr[7:0]];
    mem_rdata = mem_re ? rd_val : ~last_r;
  end
  always @(posedge mclk) begin
    if (mem_we)
      ram[mem_addr[7:0]] <= mem_wdata;
    if (mem_re)
      last_r <= rd_val;
  end
endmodule
`default_nettype wire

// ### verif/exception_interrupt_arbiter_bench.sv
/*
  self-checking bench: flags register, masking, trap, break,
  hardware entry by priority and return.
  assumes the memory model as far side.
*/
`timescale 1ns/10ps
`default_nettype none
module exception_interrupt_arbiter_bench;
  import exc_arb_pkg::*;
  logic        mclk = 1'b0, resetn = 1'b0, insn_done = 1'b0, trap_insn = 1'b0;
  logic        return_insn = 1'b0, break_req = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [10:0] irq_req = 11'h000, rq;
  logic [15:0] core_pc = 16'h0000, reg_addr = 16'h0000, mem_addr, new_pc, lpv, lax, spc, sax;
  logic [15:0] wa [8], ra [8];
  logic [7:0]  core_a = 8'h00, core_x = 8'h00, core_ccr = 8'h00, reg_wdata = 8'h00;
  logic [7:0]  mem_rdata, reg_rdata, mem_wdata, new_a, new_x, ccr_out, rv;
  logic [7:0]  wd [8];
  logic [3:0]  vector_sel;
  logic        core_hold, mem_we, mem_re, load_pc, load_regs;
  int          errors = 0, comparisons = 0, nw, nr, lpc, lv;
  integer      seed = 32'hb6be_c43a;

  exception_interrupt_arbiter exception_interrupt_arbiter_i (
    .mclk(mclk), .resetn(resetn), .irq_req(irq_req), .insn_done(insn_done),
    .trap_insn(trap_insn), .return_insn(return_insn), .break_req(break_req),
    .core_pc(core_pc), .core_a(core_a), .core_x(core_x), .core_ccr(core_ccr),
    .mem_rdata(mem_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_hold(core_hold),
    .vector_sel(vector_sel), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .mem_re(mem_re), .load_pc(load_pc), .new_pc(new_pc),
    .load_regs(load_regs), .new_a(new_a), .new_x(new_x), .ccr_out(ccr_out));
  core_mem_model core_mem_model_i (
    .mclk(mclk), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .mem_re(mem_re), .mem_rdata(mem_rdata));

  always #5 mclk = ~mclk;

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask
  task automatic setcore(input logic [7:0] c);
    @(posedge mclk);
    core_pc <= 16'($random(seed));
    core_a <= 8'($random(seed));
    core_x <= 8'($random(seed));
    core_ccr <= c;
  endtask
  // boundary event, then log memory steps; the top-priority request (level 1) arrives mid-sequence
  task automatic run(input logic t, input logic r, input logic b);
    nw = 0;
    nr = 0;
    lpc = 0;
    lax = ~{core_a, core_x};
    @(posedge mclk);
    insn_done <= 1'b1;
    trap_insn <= t;
    return_insn <= r;
    break_req <= b;
    @(posedge mclk);
    {insn_done, trap_insn, return_insn, break_req} <= 4'h0;
    for (int i = 1; i < 12; i++) begin
      @(posedge mclk);
      if (i == 2)
        irq_req <= 11'h001;
      #1;
      if (mem_we && nw < 8) begin
        wa[nw] = mem_addr;
        wd[nw] = mem_wdata;
        nw++;
      end
      if (mem_re && nr < 8) begin
        ra[nr] = mem_addr;
        nr++;
      end
      if (load_pc) begin
        lpc = i;
        lpv = new_pc;
      end
      if (load_regs)
        lax = {new_a, new_x};
    end
  endtask
  task automatic chk_entry(input logic [3:0] lvl, input logic [15:0] pcs);
    logic [7:0]  eb [5];
    logic [15:0] va;
    eb = '{pcs[7:0], pcs[15:8], core_x, core_a, core_ccr};
    va = SWI_VECTOR - {11'h000, lvl, 1'b0};
    chk(nw, 5);
    for (int k = 0; k < 5; k++) begin
      chk(wa[k], SP_RESET - 16'(k));
      chk(wd[k], eb[k]);
    end
    chk(ra[0], va);
    chk(ra[1], va + 16'h0001);
    chk(vector_sel, lvl);
    chk(lpc, 8);
    chk(lpv, {va[7:0] ^ 8'h3c, (va[7:0] + 8'h01) ^ 8'h3c});
    chk(ccr_out[IMASK_BIT], 1'b1);
  endtask
  task automatic chk_ret(input logic [15:0] pcs, input logic [15:0] ax, input logic [7:0] cc);
    chk(nr, 5);
    for (int k = 0; k < 5; k++)
      chk(ra[k], SP_RESET - 16'h0004 + 16'(k));
    chk(lpc, 6);
    chk(lpv, pcs);
    chk(lax, ax);
    chk(ccr_out, cc);
  endtask

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    rd(PENDING_LOW_ADDR);
    chk(rv, PENDING_RESET);
    chk(ccr_out, CCR_RESET);
    rd(16'hfe0f);
    chk(rv, 8'h00);
    for (int n = 0; n < 4; n++) begin
      @(posedge mclk);
      irq_req <= 11'($random(seed));
      repeat (3) @(posedge mclk);
      wr(PENDING_LOW_ADDR, 8'hff);
      rd(PENDING_LOW_ADDR);
      chk(rv, {irq_req[5:0], 2'b00});
    end
    wr(ENABLE_LO_ADDR, 8'hff);
    wr(ENABLE_HI_ADDR, 8'h07);
    setcore(CCR_RESET);
    irq_req <= 11'h7ff;
    run(1'b0, 1'b0, 1'b0);
    chk({nw[7:0], 7'h00, core_hold}, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      setcore(CCR_RESET);
      run(k == 0, 1'b0, k == 1);
      chk_entry(4'h0, core_pc);
      spc = core_pc;
      sax = {core_a, core_x};
      setcore(CCR_RESET);
      run(1'b0, 1'b1, 1'b0);
      chk_ret(spc, sax, CCR_RESET);
    end
    wr(ENABLE_LO_ADDR, 8'h00);
    wr(ENABLE_HI_ADDR, 8'h00);
    wr(CCR_ADDR, 8'h00);
    setcore(8'h00);
    irq_req <= 11'h7ff;
    run(1'b0, 1'b0, 1'b0);
    chk(nw, 0);
    wr(ENABLE_LO_ADDR, 8'hff);
    wr(ENABLE_HI_ADDR, 8'h07);
    for (int n = 0; n < 6; n++) begin
      rq = 11'($random(seed)) | 11'h400;
      if (n == 0)
        rq = 11'h400;
      wr(CCR_ADDR, 8'h00);
      setcore(8'h00);
      irq_req <= rq;
      run(1'b0, 1'b0, 1'b0);
      for (int b = 10; b >= 0; b--)
        if (rq[b])
          lv = b + 1;
      chk_entry(4'(lv), core_pc - 16'h0001);
      spc = core_pc - 16'h0001;
      sax = {core_a, core_x};
      setcore(CCR_RESET);
      run(1'b0, 1'b1, 1'b0);
      chk_ret(spc, sax, 8'h00);
    end
    wrap_up();
  end

  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
